// file: ssdbp_top.sv
// Buffer pointer and progress registers for the serial controller one DMA.
// Assumes an APB master on the system clock and a DMA sequencer that pulses
// load, unload and byte strobes; memory requests leave on registered ports.
// Transmit buffer B, error offsets and status flags live outside this block.
//
// Functional notes
// - Rx A offset readable, wraps after fill-unload
// - Rx B offset readable, wraps after fill-unload
// - One tx offset for the active buffer
// - Rx A start address writable, used first
// - Rx B start and end bound region
// - Tx A start address gives first fetch
// - Tx A end address marks last byte
// - Address bits 15:13 read 011, unwritable
//
// Our own choice: the APB interface to the registers.
`default_nettype none

module ssdbp_top
    import ssdbp_pkg::*;
#(
    parameter int unsigned AW = SSDBP_ADDR_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // DMA sequencer control, one bit per buffer (rx A, rx B, tx A)
    input wire logic [2:0] load_i,
    input wire logic [2:0] unload_i,
    // Byte strobes from the serial FIFO side
    input wire logic rx_byte_i,
    input wire logic tx_byte_i,
    // Memory side
    output logic [AW-1:0] rx_mem_addr_o,
    output logic rx_mem_we_o,
    output logic [AW-1:0] tx_mem_addr_o,
    output logic tx_mem_re_o,
    // Buffer status
    output logic [2:0] active_o,
    output logic [2:0] full_o
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration check: fixed bits sit above the address field
    if (AW < 1 || AW > SSDBP_FIXED_LSB) begin : g_bad_aw
        $error("ssdbp_top: AW must be 1 to 13");
    end

    // Flag vectors are three bits wide, one per buffer
    if (SSDBP_NUM_BUF != 3) begin : g_bad_num
        $error("ssdbp_top: three buffers expected");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Programmed addresses, one pair per buffer
    logic [AW-1:0] start_ff [SSDBP_NUM_BUF]; // Start addresses
    logic [AW-1:0] nxt_start [SSDBP_NUM_BUF];
    logic [AW-1:0] end_ff [SSDBP_NUM_BUF]; // End addresses
    logic [AW-1:0] nxt_end [SSDBP_NUM_BUF];

    // Channel status
    logic [AW-1:0] count_w [SSDBP_NUM_BUF]; // Channel offsets
    logic [AW-1:0] addr_w [SSDBP_NUM_BUF]; // Channel memory addresses
    logic [2:0] active_w; // Channel active flags
    logic [2:0] full_w; // Channel full flags
    ssdbp_ctl_t ctl_w [SSDBP_NUM_BUF]; // Channel control pulses

    // Byte routing
    logic rx_to_a; // Rx byte steered to A
    logic rx_to_b; // Rx byte steered to B
    logic tx_go; // Tx byte accepted

    // Bus answer registers
    logic [31:0] prdata_ff, nxt_prdata; // Read data
    logic pready_ff, nxt_pready; // Access complete
    logic pslverr_ff, nxt_pslverr; // Unmapped address

    // Memory request registers
    logic [AW-1:0] rx_mem_addr_ff, nxt_rx_mem_addr; // Store address
    logic rx_mem_we_ff, nxt_rx_mem_we; // Store strobe
    logic [AW-1:0] tx_mem_addr_ff, nxt_tx_mem_addr; // Fetch address
    logic tx_mem_re_ff, nxt_tx_mem_re; // Fetch strobe

    // Status copies for the outputs
    logic [2:0] active_ff, full_ff; // One cycle behind the channels

    // Bus decode helpers
    logic access; // Access phase of a transfer
    logic commit; // Edge where transfer completes
    logic [31:0] rd_word; // Decoded read value
    logic hit; // Address is mapped

    // Byte address from a register index
    function automatic logic [31:0] byte_addr(input logic [15:0] idx);
        // Index sits above the two byte-select bits
        byte_addr = {14'h0000, idx, 2'h0};
    endfunction

    // Address register read value with fixed upper bits
    function automatic logic [31:0] addr_word(input logic [AW-1:0] val);
        logic [12:0] field;
        // Narrow fields are zero-extended to 13 bits
        field = 13'(val);
        addr_word = {16'h0000, SSDBP_ADDR_FIXED, field};
    endfunction

    // Count register read value, upper bits zero
    function automatic logic [31:0] count_word(input logic [AW-1:0] val);
        logic [12:0] field;
        // Upper bits of an offset read as zero
        field = 13'(val);
        count_word = {16'h0000, SSDBP_COUNT_FIXED, field};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Byte steering
    // Rx fills A while it is active, else B; bytes with no buffer are dropped
    // A full or idle buffer never sees a strobe, so it cannot pass its end
    assign rx_to_a = rx_byte_i & active_w[SSDBP_BUF_RXA];
    assign rx_to_b = rx_byte_i & ~active_w[SSDBP_BUF_RXA] & active_w[SSDBP_BUF_RXB];

    // Tx fetches only while tx A is loaded and not yet full
    assign tx_go = tx_byte_i & active_w[SSDBP_BUF_TXA];

    ////////////////////////////////////////////////////////////////////////
    // Buffer channels
    // Each channel gets its own pulses and its own byte strobe
    for (genvar g = 0; g < SSDBP_NUM_BUF; g++) begin : g_chan
        logic byte_hit;
        // Pick this channel's byte strobe
        assign byte_hit = (g == SSDBP_BUF_RXA) ? rx_to_a :
                          (g == SSDBP_BUF_RXB) ? rx_to_b : tx_go;
        // Pack the control pulses
        assign ctl_w[g] = '{load: load_i[g], unload: unload_i[g], xfer: byte_hit};
        ssdbp_chan #(
            .AW(AW)
        ) u_chan (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .ctl_i(ctl_w[g]),
            .start_i(start_ff[g]),
            .end_i(end_ff[g]),
            .count_o(count_w[g]),
            .addr_o(addr_w[g]),
            .active_o(active_w[g]),
            .full_o(full_w[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    // Access phase: psel and penable both high
    assign access = psel_i & penable_i;

    // A one-cycle pready makes commit fire once per transfer
    assign commit = access & pready_ff;

    // Read mux and mapped check
    always_comb begin
        rd_word = 32'h0000_0000;
        hit = 1'b1;
        case (paddr_i)
            // Address registers, fixed bits above the field
            byte_addr(SSDBP_IDX_RXA_START): rd_word = addr_word(start_ff[SSDBP_BUF_RXA]);
            byte_addr(SSDBP_IDX_RXA_END): rd_word = addr_word(end_ff[SSDBP_BUF_RXA]);
            byte_addr(SSDBP_IDX_RXB_START): rd_word = addr_word(start_ff[SSDBP_BUF_RXB]);
            byte_addr(SSDBP_IDX_RXB_END): rd_word = addr_word(end_ff[SSDBP_BUF_RXB]);
            byte_addr(SSDBP_IDX_TXA_START): rd_word = addr_word(start_ff[SSDBP_BUF_TXA]);
            byte_addr(SSDBP_IDX_TXA_END): rd_word = addr_word(end_ff[SSDBP_BUF_TXA]);
            // Offset registers, read only
            byte_addr(SSDBP_IDX_RXA_COUNT): rd_word = count_word(count_w[SSDBP_BUF_RXA]);
            byte_addr(SSDBP_IDX_RXB_COUNT): rd_word = count_word(count_w[SSDBP_BUF_RXB]);
            byte_addr(SSDBP_IDX_TX_COUNT): rd_word = count_word(count_w[SSDBP_BUF_TXA]);
            // Unmapped words answer with an error
            default: hit = 1'b0;
        endcase
    end

    // Bus answer: one wait state, data and error with pready
    always_comb begin
        // One wait state, then a single-cycle pready
        nxt_pready = access & ~pready_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        // First access cycle: load the answer for the next edge
        if (access & ~pready_ff) begin
            // Writes read back zero data
            nxt_prdata = pwrite_i ? 32'h0000_0000 : rd_word;
            nxt_pslverr = ~hit;
        end
    end

    // Address register writes, low 13 bits only
    always_comb begin
        // Start and end pairs are two strides apart per buffer
        for (int i = 0; i < SSDBP_NUM_BUF; i++) begin
            nxt_start[i] = start_ff[i];
            nxt_end[i] = end_ff[i];
            // Count registers and unmapped words ignore writes
            // A write lands at the completing edge, both low lanes enabled
            if (commit && pwrite_i && hit && pstrb_i[1:0] == 2'h3) begin
                if (paddr_i == byte_addr(16'(SSDBP_IDX_RXA_START + 16'(i) * 2 * SSDBP_IDX_STEP))) begin
                    nxt_start[i] = pwdata_i[AW-1:0];
                end
                if (paddr_i == byte_addr(16'(SSDBP_IDX_RXA_END + 16'(i) * 2 * SSDBP_IDX_STEP))) begin
                    nxt_end[i] = pwdata_i[AW-1:0];
                end
            end
        end
    end

    // Memory side requests, one per moved byte
    always_comb begin
        // Store strobe for any accepted rx byte
        nxt_rx_mem_we = rx_to_a | rx_to_b;
        // Address holds between stores
        nxt_rx_mem_addr = rx_mem_addr_ff;
        if (rx_to_a) begin
            nxt_rx_mem_addr = addr_w[SSDBP_BUF_RXA];
        end else if (rx_to_b) begin
            nxt_rx_mem_addr = addr_w[SSDBP_BUF_RXB];
        end

        // Fetch strobe and address, address held between fetches
        nxt_tx_mem_re = tx_go;
        nxt_tx_mem_addr = tx_go ? addr_w[SSDBP_BUF_TXA] : tx_mem_addr_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // Programmed addresses cleared
            for (int i = 0; i < SSDBP_NUM_BUF; i++) begin
                start_ff[i] <= SSDBP_ADDR_RST[AW-1:0];
                end_ff[i] <= SSDBP_ADDR_RST[AW-1:0];
            end

            // No answer pending
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;

            // No memory request
            rx_mem_addr_ff <= SSDBP_ADDR_RST[AW-1:0];
            rx_mem_we_ff <= 1'b0;
            tx_mem_addr_ff <= SSDBP_ADDR_RST[AW-1:0];
            tx_mem_re_ff <= 1'b0;

            // All buffers shown idle
            active_ff <= 3'h0;
            full_ff <= 3'h0;
        end else begin
            // Programmed addresses
            for (int i = 0; i < SSDBP_NUM_BUF; i++) begin
                start_ff[i] <= nxt_start[i];
                end_ff[i] <= nxt_end[i];
            end

            // Bus answer
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;

            // Memory requests
            rx_mem_addr_ff <= nxt_rx_mem_addr;
            rx_mem_we_ff <= nxt_rx_mem_we;
            tx_mem_addr_ff <= nxt_tx_mem_addr;
            tx_mem_re_ff <= nxt_tx_mem_re;

            // Status one cycle behind the channels
            active_ff <= active_w;
            full_ff <= full_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Bus answer
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;

    // Memory requests
    assign rx_mem_addr_o = rx_mem_addr_ff;
    assign rx_mem_we_o = rx_mem_we_ff;
    assign tx_mem_addr_o = tx_mem_addr_ff;
    assign tx_mem_re_o = tx_mem_re_ff;

    // Buffer status
    assign active_o = active_ff;
    assign full_o = full_ff;

endmodule

`default_nettype wire

// file: ssdbp_pkg.sv
// Shared constants and types for the serial DMA buffer pointer block.
// Assumes a single system clock with a synchronous, active-high reset.
`default_nettype none

package ssdbp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned SSDBP_ADDR_W = 13;     // Buffer address and offset width
    localparam int unsigned SSDBP_REG_W = 16;      // Register width as seen by software
    localparam int unsigned SSDBP_NUM_BUF = 3;     // Rx A, rx B, tx A

    ////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index)
    localparam logic [15:0] SSDBP_IDX_RXA_START = 16'h4480;
    localparam logic [15:0] SSDBP_IDX_RXA_END = 16'h4482;
    localparam logic [15:0] SSDBP_IDX_RXB_START = 16'h4484;
    localparam logic [15:0] SSDBP_IDX_RXB_END = 16'h4486;
    localparam logic [15:0] SSDBP_IDX_TXA_START = 16'h4488;
    localparam logic [15:0] SSDBP_IDX_TXA_END = 16'h448a;
    localparam logic [15:0] SSDBP_IDX_RXA_COUNT = 16'h4490;
    localparam logic [15:0] SSDBP_IDX_RXB_COUNT = 16'h4492;
    localparam logic [15:0] SSDBP_IDX_TX_COUNT = 16'h4494;
    localparam logic [15:0] SSDBP_IDX_STEP = 16'h0002;  // Start to end; buffer to buffer is twice this

    ////////////////////////////////////////////////////////////////////////
    // Field layout and reset values
    localparam int unsigned SSDBP_FIXED_LSB = 13;       // Fixed bits 15:13 of address regs
    localparam logic [2:0] SSDBP_ADDR_FIXED = 3'h3;     // Bit 15 zero, bits 14:13 one
    localparam logic [2:0] SSDBP_COUNT_FIXED = 3'h0;    // Count regs: upper bits zero
    localparam logic [12:0] SSDBP_ADDR_RST = 13'h0000;  // Start and end reset value
    localparam logic [12:0] SSDBP_COUNT_RST = 13'h0000; // Offset reset value

    ////////////////////////////////////////////////////////////////////////
    // Buffer index assignment
    localparam int unsigned SSDBP_BUF_RXA = 0;
    localparam int unsigned SSDBP_BUF_RXB = 1;
    localparam int unsigned SSDBP_BUF_TXA = 2;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        SSDBP_IDLE = 3'b001,    // Unloaded, offset at zero
        SSDBP_ACTIVE = 3'b010,  // Loaded, moving bytes
        SSDBP_FULL = 3'b100     // End reached, waiting for unload
    } ssdbp_state_t;

    typedef struct packed {
        logic load;    // Pulse: buffer loaded
        logic unload;  // Pulse: buffer unloaded
        logic xfer;    // Pulse: one byte moved
    } ssdbp_ctl_t;

endpackage

`default_nettype wire

// file: ssdbp_chan.sv
// One DMA buffer channel: byte offset counter and load state.
// Assumes load, unload and xfer are one-cycle pulses from the parent.
`default_nettype none

module ssdbp_chan
    import ssdbp_pkg::*;
#(
    parameter int unsigned AW = SSDBP_ADDR_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire ssdbp_ctl_t ctl_i,
    input wire logic [AW-1:0] start_i,
    input wire logic [AW-1:0] end_i,
    // Status
    output logic [AW-1:0] count_o,
    output logic [AW-1:0] addr_o,
    output logic active_o,
    output logic full_o
);

    // Offsets wider than the reset constant cannot be served
    if (AW < 1 || AW > SSDBP_ADDR_W) begin : g_bad_aw
        $error("ssdbp_chan: AW must be 1 to 13");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    ssdbp_state_t state_ff, nxt_state;  // Buffer state
    logic [AW-1:0] count_ff, nxt_count; // Next byte offset

    // Next memory location is start plus offset
    assign addr_o = AW'(start_i + count_ff);
    assign count_o = count_ff;
    assign active_o = (state_ff == SSDBP_ACTIVE);
    assign full_o = (state_ff == SSDBP_FULL);

    // Next state and offset
    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        case (state_ff)
            SSDBP_IDLE: begin
                // Loading starts at offset zero
                if (ctl_i.load) begin
                    nxt_state = SSDBP_ACTIVE;
                    nxt_count = SSDBP_COUNT_RST[AW-1:0];
                end
            end
            SSDBP_ACTIVE: begin
                if (ctl_i.unload) begin
                    // Early unload still wraps the offset
                    nxt_state = SSDBP_IDLE;
                    nxt_count = SSDBP_COUNT_RST[AW-1:0];
                end else if (ctl_i.xfer) begin
                    nxt_count = AW'(count_ff + 1'b1);
                    // Byte at the end address fills the buffer
                    if (addr_o == end_i) begin
                        nxt_state = SSDBP_FULL;
                    end
                end
            end
            SSDBP_FULL: begin
                // Wrap to zero after fill and unload
                if (ctl_i.unload) begin
                    nxt_state = SSDBP_IDLE;
                    nxt_count = SSDBP_COUNT_RST[AW-1:0];
                end
            end
            default: begin
                nxt_state = SSDBP_IDLE;
                nxt_count = SSDBP_COUNT_RST[AW-1:0];
            end
        endcase
    end

    // Register state
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_ff <= SSDBP_IDLE;
            count_ff <= SSDBP_COUNT_RST[AW-1:0];
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
        end
    end

endmodule

`default_nettype wire

// file: ssdbp_chk.sv
// Checker for ssdbp_top: readback fields, strobe causes, fill stop.
// Assumes it is bound to ssdbp_top and sees only its ports.
`default_nettype none

module ssdbp_chk
    import ssdbp_pkg::*;
#(
    parameter int unsigned AW = SSDBP_ADDR_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // DMA
    input wire logic [2:0] unload_i,
    input wire logic rx_byte_i,
    input wire logic tx_byte_i,
    input wire logic rx_mem_we_o,
    input wire logic [AW-1:0] tx_mem_addr_o,
    input wire logic tx_mem_re_o,
    input wire logic [2:0] active_o,
    input wire logic [2:0] full_o
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////
    // Good read finishing, and its register group
    wire logic rd_ok = psel_i && penable_i && !pwrite_i && pready_o && !pslverr_o;
    wire logic in_addr = paddr_i >= 32'h11200 && paddr_i <= 32'h11228;
    wire logic in_cnt = paddr_i >= 32'h11240 && paddr_i <= 32'h11250;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////
    property p_addr_bits; rd_ok && in_addr |-> prdata_o[31:13] == 19'h3; endproperty
    a_addr_bits: assert property (p_addr_bits) else $error("address reg upper bits wrong");
    property p_cnt_bits; rd_ok && in_cnt |-> prdata_o[31:13] == 19'h0; endproperty
    a_cnt_bits: assert property (p_cnt_bits) else $error("count reg upper bits wrong");
    property p_rx_cause; rx_mem_we_o |-> $past(rx_byte_i); endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("store without byte");
    property p_tx_cause; tx_mem_re_o |-> $past(tx_byte_i); endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("fetch without byte");
    property p_tx_step; tx_mem_re_o && $past(tx_mem_re_o) |-> tx_mem_addr_o == $past(tx_mem_addr_o) + AW'(1); endproperty
    a_tx_step: assert property (p_tx_step) else $error("fetch address not stepping by one");
    property p_tx_stop; $stable(full_o[2]) && full_o[2] |-> !tx_mem_re_o; endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("fetch while tx full");
    property p_rx_stop; (full_o[1:0] == 2'h3) [*2] |-> !rx_mem_we_o; endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("store while both rx full");
    property p_unl_a; unload_i[0] |-> ##2 (!active_o[0] && !full_o[0]); endproperty
    a_unl_a: assert property (p_unl_a) else $error("rx a not idle after unload");
    property p_unl_b; unload_i[1] |-> ##2 (!active_o[1] && !full_o[1]); endproperty
    a_unl_b: assert property (p_unl_b) else $error("rx b not idle after unload");
endmodule

`default_nettype wire

// file: ssdbp_far.sv
// Far side model: serial FIFO byte strobes and a RAM logging accesses.
// Assumes the bench calls send() and reads the logs by hierarchy.
`default_nettype none

module ssdbp_far (
    // Clock
    input wire logic ref_clk_i,
    // Byte strobes
    output logic rx_byte_o,
    output logic tx_byte_o,
    // Memory requests
    input wire logic [12:0] rx_mem_addr_i,
    input wire logic rx_mem_we_i,
    input wire logic [12:0] tx_mem_addr_i,
    input wire logic tx_mem_re_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [12:0] rx_log[$]; // Stored byte addresses
    logic [12:0] tx_log[$]; // Fetched byte addresses

    initial begin
        rx_byte_o = 1'h0;
        tx_byte_o = 1'h0;
    end

    ////////////////////////////////////////
    // RAM: one logged access per strobe
    always @(posedge ref_clk_i) begin
        if (rx_mem_we_i === 1'h1) begin
            rx_log.push_back(rx_mem_addr_i);
        end
        if (tx_mem_re_i === 1'h1) begin
            tx_log.push_back(tx_mem_addr_i);
        end
    end

    // FIFO: n bytes on consecutive edges
    task automatic send(input logic is_tx, input int n);
        @(posedge ref_clk_i);
        rx_byte_o <= !is_tx;
        tx_byte_o <= is_tx;
        repeat (n) @(posedge ref_clk_i);
        rx_byte_o <= 1'h0;
        tx_byte_o <= 1'h0;
    endtask
endmodule

`default_nettype wire

// file: tb_top.sv
// Top bench: APB master, load/unload pulses and scenario tasks.
// Assumes the package, design, checker and far model compile first.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, rd_err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd_data;
    logic [3:0] pstrb = 4'h0;
    logic [2:0] load = 3'h0, unload = 3'h0, active, full;
    logic rx_byte, tx_byte, rx_we, tx_re;
    logic [12:0] rx_addr, tx_addr;
    int num_errors = 0, cmp_count = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    ssdbp_top #(.AW(13)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .load_i(load), .unload_i(unload), .rx_byte_i(rx_byte),
        .tx_byte_i(tx_byte), .rx_mem_addr_o(rx_addr), .rx_mem_we_o(rx_we), .tx_mem_addr_o(tx_addr),
        .tx_mem_re_o(tx_re), .active_o(active), .full_o(full));
    ssdbp_far far_u (.ref_clk_i(ref_clk_i), .rx_byte_o(rx_byte), .tx_byte_o(tx_byte),
        .rx_mem_addr_i(rx_addr), .rx_mem_we_i(rx_we), .tx_mem_addr_i(tx_addr), .tx_mem_re_i(tx_re));

    ////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One transfer; answer taken at the edge that samples pready
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk_i);
        penable <= 1'h1;
        // Values read right after the edge are those the slave sampled
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            num_errors++;
            $display("unexpected pready: expected 1, seen timeout");
            close_out();
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        apb(1'h0, a, 32'h0, 4'h0);
        chk(what, exp, rd_data);
    endtask

    // Load and unload pulses, one cycle
    task automatic ctl(input logic [2:0] ld, input logic [2:0] ul);
        @(posedge ref_clk_i);
        load <= ld;
        unload <= ul;
        @(posedge ref_clk_i);
        load <= 3'h0;
        unload <= 3'h0;
    endtask

    ////////////////////////////////////////
    // Reset values, fixed bits, refused writes, unmapped place
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            rd(32'h11200 + 32'(8 * i), 32'h6000, "addr reg reset");
            apb(1'h1, 32'h11200 + 32'(8 * i), 32'hffff_ffff, 4'hf);
            rd(32'h11200 + 32'(8 * i), 32'h7fff, "addr reg ones");
        end
        apb(1'h1, 32'h11200, 32'h0, 4'hc);
        rd(32'h11200, 32'h7fff, "partial strobe write");
        for (int i = 0; i < 3; i++) begin
            apb(1'h1, 32'h11240 + 32'(8 * i), 32'hffff_ffff, 4'hf);
            rd(32'h11240 + 32'(8 * i), 32'h0, "count reg written");
        end
        apb(1'h0, 32'h11230, 32'h0, 4'h0);
        chk("unmapped error", 32'h1, {31'h0, rd_err});
        $display("test regs done");
    endtask

    // Rx A fills, spill to B, a dropped byte, then unload
    task automatic t_rx();
        logic [12:0] exp[5] = '{13'h100, 13'h101, 13'h102, 13'h200, 13'h201};
        apb(1'h1, 32'h11200, 32'h100, 4'hf);
        apb(1'h1, 32'h11208, 32'h102, 4'hf);
        apb(1'h1, 32'h11210, 32'h200, 4'hf);
        apb(1'h1, 32'h11218, 32'h201, 4'hf);
        ctl(3'h3, 3'h0);
        far_u.send(1'h0, 6);
        repeat (3) @(posedge ref_clk_i);
        chk("rx store count", 32'h5, 32'(far_u.rx_log.size()));
        for (int i = 0; i < 5; i++) begin
            chk("rx store address", {19'h0, exp[i]}, {19'h0, far_u.rx_log[i]});
        end
        rd(32'h11240, 32'h3, "rx a count full");
        rd(32'h11248, 32'h2, "rx b count full");
        chk("full flags", 32'h3, {29'h0, full});
        ctl(3'h0, 3'h3);
        rd(32'h11240, 32'h0, "rx a count unloaded");
        rd(32'h11248, 32'h0, "rx b count unloaded");
        chk("full flags", 32'h0, {29'h0, full});
        $display("test rx done");
    endtask

    // Tx fills, extra byte refused, unload, reload restarts
    task automatic t_tx();
        apb(1'h1, 32'h11220, 32'h300, 4'hf);
        apb(1'h1, 32'h11228, 32'h303, 4'hf);
        ctl(3'h4, 3'h0);
        far_u.send(1'h1, 4);
        repeat (3) @(posedge ref_clk_i);
        far_u.send(1'h1, 1);
        repeat (3) @(posedge ref_clk_i);
        chk("tx fetch count", 32'h4, 32'(far_u.tx_log.size()));
        chk("tx first fetch", 32'h300, {19'h0, far_u.tx_log[0]});
        chk("tx last fetch", 32'h303, {19'h0, far_u.tx_log[3]});
        rd(32'h11250, 32'h4, "tx count full");
        chk("full flags", 32'h4, {29'h0, full});
        ctl(3'h0, 3'h4);
        rd(32'h11250, 32'h0, "tx count unloaded");
        ctl(3'h4, 3'h0);
        far_u.send(1'h1, 2);
        rd(32'h11250, 32'h2, "tx count reloaded");
        chk("active flags", 32'h4, {29'h0, active});
        chk("tx refetch start", 32'h300, {19'h0, far_u.tx_log[4]});
        $display("test tx done");
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_rx();
        t_tx();
        close_out();
    end
endmodule

bind ssdbp_top ssdbp_chk #(.AW(AW)) chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .unload_i(unload_i), .rx_byte_i(rx_byte_i), .tx_byte_i(tx_byte_i),
    .rx_mem_we_o(rx_mem_we_o), .tx_mem_addr_o(tx_mem_addr_o), .tx_mem_re_o(tx_mem_re_o),
    .active_o(active_o), .full_o(full_o));

`default_nettype wire
